// *** src/iwpb_pkg.sv ***
// package of constants and types for the idle wake and peripheral bus clock block
package iwpb_pkg;
	localparam int          PRIO_W          = 3;
	localparam int          DIV_SEL_W       = 2;
	localparam int          DIV_SEL_LSB     = 19;
	localparam int          DIV_SEL_MSB     = 20;
	localparam int          SLEEP_SEL_BIT   = 4;
	localparam logic [1:0]  DIV_SEL_RESET   = 2'h0;
	localparam logic [2:0]  DIV_CNT_RESET   = 3'h0;
	localparam int          CLK_PERIOD_NS   = 10;

	typedef enum logic [1:0] {
		IWPB_RATIO_1 = 2'h0,
		IWPB_RATIO_2 = 2'h1,
		IWPB_RATIO_4 = 2'h2,
		IWPB_RATIO_8 = 2'h3
	} iwpb_ratio_t;

	typedef enum logic [1:0] {
		IWPB_RUN  = 2'h0,
		IWPB_IDLE = 2'h1
	} iwpb_pmode_t;

	typedef enum logic [1:0] {
		IWPB_RD_FREE = 2'h0,
		IWPB_RD_WAIT = 2'h1
	} iwpb_rdst_t;

	typedef struct packed {
		logic              valid;
		logic [PRIO_W-1:0] prio;
	} iwpb_irq_t;

	typedef struct packed {
		logic        halt_req;
		logic        sleep_sel;
		logic        wdt_timeout;
		logic        sys_reset;
	} iwpb_pwr_req_t;
endpackage : iwpb_pkg

// *** src/iwpb_divider.sv ***
// divider producing the peripheral bus clock enable from the system clock
`timescale 1ns/10ps
module iwpb_divider (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                resetn,
	// ratio select
	input  wire iwpb_pkg::iwpb_ratio_t ratio,
	// divided clock
	output logic                     pb_clk_q,
	output logic                     pb_rise_q
);
	iwpb_pkg::iwpb_ratio_t ratio_q;
	logic [2:0]            cnt_q;
	logic [2:0]            cnt_d;
	logic [2:0]            last;
	logic                  wrap;

	function automatic logic [2:0] ratio_last(input iwpb_pkg::iwpb_ratio_t r);
		unique case (r)
			iwpb_pkg::IWPB_RATIO_1: ratio_last = 3'h0;
			iwpb_pkg::IWPB_RATIO_2: ratio_last = 3'h1;
			iwpb_pkg::IWPB_RATIO_4: ratio_last = 3'h3;
			iwpb_pkg::IWPB_RATIO_8: ratio_last = 3'h7;
		endcase
	endfunction : ratio_last

	// ratio held for a whole period; a new select takes hold only at the wrap, so no runt pulse [R11]
	always_comb begin
		last  = ratio_last(ratio_q);
		wrap  = (cnt_q >= last);
		cnt_d = wrap ? 3'h0 : cnt_q + 3'h1;
	end

	// ratio latch, 1:1 straight after reset [R12] [R11]
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ratio_q <= iwpb_pkg::iwpb_ratio_t'(iwpb_pkg::DIV_SEL_RESET);
		end else if (wrap) begin
			ratio_q <= ratio;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= iwpb_pkg::DIV_CNT_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// rising edge marker of the divided clock [R5]
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pb_rise_q <= 1'b0;
			pb_clk_q  <= 1'b0;
		end else begin
			pb_rise_q <= (cnt_d == 3'h0);
			pb_clk_q  <= (last == 3'h0) ? 1'b1 : (cnt_d <= (last >> 1));
		end
	end
endmodule : iwpb_divider

// *** src/iwpb_top.sv ***
// idle mode wake control and peripheral bus clock scaling
// Functional notes
// [R1] wake from idle on enabled interrupt with priority above current cpu priority
// [R2] enabled interrupt at or below cpu priority keeps cpu halted in idle
// [R3] any device reset ends idle mode
// [R4] watchdog time-out wakes the processor out of idle
// [R5] bus clock is system clock divided 1,2,4,8 by select bits 20:19
// [R6] system-clock peripherals unaffected by divider; others use bus clock
// [R7] peripheral read completes at next bus clock rising edge; cpu stalls until then
// [R8] with divide by eight, added read latency is one to seven cycles; code adds zero to seven, none when the read meets a bus clock edge
// [R9] idle entered when sleep select clear and halt instruction executes
// [R10] in idle cpu halts, clock runs, stop-in-idle peripherals halt
// [R11] select codes 00..11 give 1:1..1:8; ratio change is glitch free
// [R12] after reset ratio is 1:1 and device is not idle
`timescale 1ns/10ps
module iwpb_top (
	// clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          resetn,
	// oscillator control word
	input  wire logic [31:0]                   osc_control_reg,
	// cpu power requests
	input  wire iwpb_pkg::iwpb_pwr_req_t       pwr_req,
	input  wire logic [iwpb_pkg::PRIO_W-1:0]   cpu_prio,
	input  wire iwpb_pkg::iwpb_irq_t           irq,
	// cpu peripheral read
	input  wire logic                          periph_rd_req,
	input  wire logic                          periph_rd_on_system_clock,
	// stop-in-idle bits of peripherals
	input  wire logic [7:0]                    stop_in_idle_bit,
	// status and clocks
	output logic                               cpu_halted_q,
	output logic                               idle_q,
	output logic                               cpu_stall_q,
	output logic                               periph_rd_done_q,
	output logic                               periph_bus_clock_q,
	output logic                               periph_bus_clk_en_q,
	output logic [7:0]                         periph_halt_q
);
	iwpb_pkg::iwpb_pmode_t mode_q;
	iwpb_pkg::iwpb_pmode_t mode_d;
	iwpb_pkg::iwpb_rdst_t  rd_q;
	iwpb_pkg::iwpb_rdst_t  rd_d;
	iwpb_pkg::iwpb_ratio_t periph_bus_divider_sel;
	logic                  pb_clk;
	logic                  pb_rise;
	logic                  wake;
	logic                  halt_ok;
	logic                  idle_d;
	logic                  rd_direct;
	logic                  rd_park;

	// irq priority strictly above the cpu priority [R1] [R2]
	function automatic logic prio_above(
		input iwpb_pkg::iwpb_irq_t         ev,
		input logic [iwpb_pkg::PRIO_W-1:0] cur
	);
		prio_above = ev.valid && (ev.prio > cur);
	endfunction : prio_above

	// halt instruction that may enter idle [R9]
	function automatic logic halt_allowed(
		input iwpb_pkg::iwpb_pwr_req_t req
	);
		halt_allowed = req.halt_req && !req.sleep_sel && !req.sys_reset;
	endfunction : halt_allowed

	// read that completes in the next cycle [R6] [R7]
	function automatic logic read_direct(
		input logic req,
		input logic on_sys,
		input logic rise
	);
		read_direct = req && (on_sys || rise);
	endfunction : read_direct

	// read that must wait for the next bus clock rising edge [R7]
	function automatic logic read_parks(
		input logic req,
		input logic on_sys,
		input logic rise
	);
		read_parks = req && !on_sys && !rise;
	endfunction : read_parks

	// select field decode, codes map straight to ratios [R5] [R11]
	assign periph_bus_divider_sel = iwpb_pkg::iwpb_ratio_t'(
		osc_control_reg[iwpb_pkg::DIV_SEL_MSB:iwpb_pkg::DIV_SEL_LSB]);

	iwpb_divider u_div (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.ratio     (periph_bus_divider_sel),
		.pb_clk_q  (pb_clk),
		.pb_rise_q (pb_rise)
	);

	// wake causes: higher priority irq, watchdog, reset [R1] [R2] [R3] [R4]
	assign wake    = prio_above(irq, cpu_prio) || pwr_req.wdt_timeout || pwr_req.sys_reset;
	assign halt_ok = halt_allowed(pwr_req);

	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			iwpb_pkg::IWPB_RUN: begin
				if (halt_ok) begin
					mode_d = iwpb_pkg::IWPB_IDLE; // [R9]
				end
			end
			iwpb_pkg::IWPB_IDLE: begin
				if (wake) begin
					mode_d = iwpb_pkg::IWPB_RUN; // [R1] [R3] [R4]
				end
			end
			default: mode_d = iwpb_pkg::IWPB_RUN;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= iwpb_pkg::IWPB_RUN; // [R12] [R3]
		end else begin
			mode_q <= mode_d;
		end
	end

	// next idle state shared by the status flops
	assign idle_d = (mode_d == iwpb_pkg::IWPB_IDLE);

	// idle flag [R9] [R1]
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			idle_q <= 1'b0;
		end else begin
			idle_q <= idle_d;
		end
	end

	// cpu halted while idle, system clock keeps running [R10] [R2]
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cpu_halted_q <= 1'b0;
		end else begin
			cpu_halted_q <= idle_d;
		end
	end

	// stop-in-idle peripherals halt while idle [R10]
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			periph_halt_q <= 8'h00;
		end else begin
			periph_halt_q <= idle_d ? stop_in_idle_bit : 8'h00;
		end
	end

	// divided bus clock out; system-clock peripherals do not use it [R6]
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			periph_bus_clock_q <= 1'b0;
		end else begin
			periph_bus_clock_q <= pb_clk;
		end
	end

	// one-cycle marker of each bus clock rising edge [R5]
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			periph_bus_clk_en_q <= 1'b0;
		end else begin
			periph_bus_clk_en_q <= pb_rise;
		end
	end

	// read decode [R7]
	assign rd_direct = read_direct(periph_rd_req, periph_rd_on_system_clock, pb_rise);
	assign rd_park   = read_parks(periph_rd_req, periph_rd_on_system_clock, pb_rise);

	// read waits for next bus clock rising edge [R7] [R8]
	always_comb begin
		rd_d = rd_q;
		unique case (rd_q)
			iwpb_pkg::IWPB_RD_FREE: begin
				if (rd_park) begin
					rd_d = iwpb_pkg::IWPB_RD_WAIT;
				end
			end
			iwpb_pkg::IWPB_RD_WAIT: begin
				if (pb_rise) begin
					rd_d = iwpb_pkg::IWPB_RD_FREE;
				end
			end
			default: rd_d = iwpb_pkg::IWPB_RD_FREE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rd_q <= iwpb_pkg::IWPB_RD_FREE;
		end else begin
			rd_q <= rd_d;
		end
	end

	// cpu stalls while the read waits [R7]
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cpu_stall_q <= 1'b0;
		end else begin
			cpu_stall_q <= (rd_d == iwpb_pkg::IWPB_RD_WAIT);
		end
	end

	// one-cycle done pulse [R7] [R8]
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			periph_rd_done_q <= 1'b0;
		end else begin
			periph_rd_done_q <= (rd_q == iwpb_pkg::IWPB_RD_WAIT && pb_rise)
				|| (rd_q == iwpb_pkg::IWPB_RD_FREE && rd_direct);
		end
	end
endmodule : iwpb_top

// *** sim/iwpb_asserts.sv ***
// concurrent checks on the idle wake and bus clock ports
`timescale 1ns/10ps
module iwpb_asserts (
	// clock and reset
	input wire logic                    ref_clk,
	input wire logic                    resetn,
	// requests
	input wire logic [31:0]             osc_control_reg,
	input wire iwpb_pkg::iwpb_pwr_req_t pwr_req,
	input wire logic [iwpb_pkg::PRIO_W-1:0] cpu_prio,
	input wire iwpb_pkg::iwpb_irq_t     irq,
	input wire logic                    periph_rd_req,
	// status
	input wire logic                    cpu_halted_q,
	input wire logic                    idle_q,
	input wire logic                    cpu_stall_q,
	input wire logic                    periph_rd_done_q,
	input wire logic                    periph_bus_clock_q,
	input wire logic                    periph_bus_clk_en_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire w  = irq.valid && irq.prio > cpu_prio;
	wire s8 = osc_control_reg[iwpb_pkg::DIV_SEL_MSB:iwpb_pkg::DIV_SEL_LSB] == iwpb_pkg::IWPB_RATIO_8;
	a_irq_wake_up: assert property (idle_q && w |=> !idle_q) else $error("no wake on irq");
	a_low_prio_stay: assert property (idle_q && !w && !pwr_req.wdt_timeout && !pwr_req.sys_reset |=> idle_q)
		else $error("left idle");
	a_reset_ends_idle: assert property (pwr_req.sys_reset |=> !idle_q) else $error("idle in reset");
	a_wdt_wake_up: assert property (idle_q && pwr_req.wdt_timeout |=> !idle_q) else $error("no wdt wake");
	a_halt_enters_idle: assert property (!idle_q && pwr_req.halt_req && !pwr_req.sleep_sel
		&& !pwr_req.sys_reset |=> idle_q) else $error("no idle entry");
	a_cpu_halt_idle: assert property (cpu_halted_q == idle_q) else $error("halt mismatch");
	a_read_done_bound: assert property (periph_rd_req && !cpu_stall_q |-> ##[1:8] periph_rd_done_q)
		else $error("read too slow");
	a_done_on_edge: assert property (periph_rd_done_q && $past(cpu_stall_q) |-> periph_bus_clk_en_q)
		else $error("done off edge");
	a_div8_period: assert property (periph_bus_clk_en_q && $past(s8) |=> !periph_bus_clk_en_q [*7]
		##1 periph_bus_clk_en_q) else $error("bad 1:8 period");
	a_rise_has_mark: assert property ($rose(periph_bus_clock_q) |-> periph_bus_clk_en_q)
		else $error("bus clock rose off marker");
	a_mark_clock_high: assert property (periph_bus_clk_en_q |-> periph_bus_clock_q)
		else $error("marker while bus clock low");
	c_wake: cover property (idle_q ##1 !idle_q);
	c_wait_read: cover property (periph_rd_done_q && $past(cpu_stall_q));
	c_div8: cover property (periph_bus_clk_en_q && s8);
endmodule : iwpb_asserts
bind iwpb_top iwpb_asserts u_iwpb_asserts (
	.ref_clk             (ref_clk),
	.resetn              (resetn),
	.osc_control_reg     (osc_control_reg),
	.pwr_req             (pwr_req),
	.cpu_prio            (cpu_prio),
	.irq                 (irq),
	.periph_rd_req       (periph_rd_req),
	.cpu_halted_q        (cpu_halted_q),
	.idle_q              (idle_q),
	.cpu_stall_q         (cpu_stall_q),
	.periph_rd_done_q    (periph_rd_done_q),
	.periph_bus_clock_q  (periph_bus_clock_q),
	.periph_bus_clk_en_q (periph_bus_clk_en_q)
);

// *** sim/iwpb_periph_model.sv ***
// bus clocked peripheral counting its clock ticks
`timescale 1ns/10ps
module iwpb_periph_model (
	// clock and reset
	input  wire logic  ref_clk,
	input  wire logic  resetn,
	// bus clock and idle halt
	input  wire logic  bus_en,
	input  wire logic  halt,
	// activity
	output logic [15:0] ticks_q
);
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) ticks_q <= 16'h0;
		else if (bus_en && !halt) ticks_q <= ticks_q + 16'h1;
	end
endmodule : iwpb_periph_model

// *** sim/idle_wake_and_pb_clock_divider_tb.sv ***
// self-checking bench for the idle wake and bus clock block
`timescale 1ns/10ps
module idle_wake_and_pb_clock_divider_tb;
	logic ref_clk = 1'h0, resetn = 1'h0, periph_rd_req = 1'h0, periph_rd_on_system_clock = 1'h0;
	logic [31:0] osc_control_reg = 32'h0;
	iwpb_pkg::iwpb_pwr_req_t pwr_req = 4'h0;
	iwpb_pkg::iwpb_irq_t irq = 4'h0;
	logic [2:0] cpu_prio = 3'h0, p;
	logic [7:0] stop_in_idle_bit = 8'h0, periph_halt_q;
	logic cpu_halted_q, idle_q, cpu_stall_q, periph_rd_done_q, periph_bus_clock_q, periph_bus_clk_en_q;
	logic [15:0] ticks_q, t;
	int n_fail = 0, total_checks = 0, seed = 61, n, i;
	iwpb_top u_iwpb_top (
		.ref_clk             (ref_clk),
		.resetn              (resetn),
		.osc_control_reg     (osc_control_reg),
		.pwr_req             (pwr_req),
		.cpu_prio            (cpu_prio),
		.irq                 (irq),
		.periph_rd_req       (periph_rd_req),
		.periph_rd_on_system_clock (periph_rd_on_system_clock),
		.stop_in_idle_bit    (stop_in_idle_bit),
		.cpu_halted_q        (cpu_halted_q),
		.idle_q              (idle_q),
		.cpu_stall_q         (cpu_stall_q),
		.periph_rd_done_q    (periph_rd_done_q),
		.periph_bus_clock_q  (periph_bus_clock_q),
		.periph_bus_clk_en_q (periph_bus_clk_en_q),
		.periph_halt_q       (periph_halt_q)
	);
	iwpb_periph_model u_iwpb_periph_model (.ref_clk, .resetn, .bus_en(periph_bus_clk_en_q),
		.halt(periph_halt_q[0]), .ticks_q);
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(int k);
		repeat (k) @(negedge ref_clk);
	endtask : cyc
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	initial forever #5 ref_clk = ~ref_clk;
	initial begin
		#100000;
		n_fail++;
		print_verdict();
	end
	initial begin
		cyc(12);
		resetn = 1'h1;
		cyc(2);
		chk("idle", 0, idle_q);
		chk("en", 1, periph_bus_clk_en_q);
		for (i = 0; i < 40; i++) begin
			pwr_req = 4'h8 | 4'h4;
			cyc(1);
			pwr_req = 4'h0;
			chk("sleepsel", 0, idle_q);
			stop_in_idle_bit = 8'($random(seed));
			pwr_req.halt_req = 1'h1;
			cyc(1);
			pwr_req = 4'h0;
			chk("idle", 1, idle_q);
			cyc(1);
			chk("phalt", stop_in_idle_bit, periph_halt_q);
			t = ticks_q;
			cyc(3);
			if (stop_in_idle_bit[0]) chk("ticks", t, ticks_q);
			else chk("ticks", t + 16'h3, ticks_q);
			cpu_prio = 3'($random(seed));
			p = (i < 4) ? cpu_prio : 3'($random(seed));
			irq = {1'h1, p};
			cyc(1);
			irq = 4'h0;
			chk("wake", p <= cpu_prio, idle_q);
			pwr_req.wdt_timeout = i[0];
			pwr_req.sys_reset = !i[0];
			cyc(1);
			pwr_req = 4'h0;
			chk("wdtrst", 0, idle_q);
		end
		pwr_req.halt_req = 1'h1;
		cyc(1);
		pwr_req = 4'h0;
		chk("idle", 1, idle_q);
		resetn = 1'h0;
		cyc(2);
		chk("rstidle", 0, idle_q);
		resetn = 1'h1;
		cyc(2);
		chk("idle", 0, idle_q);
		chk("en", 1, periph_bus_clk_en_q);
		$display("idle test done");
		for (i = 0; i < 64; i++) begin
			osc_control_reg[iwpb_pkg::DIV_SEL_MSB:iwpb_pkg::DIV_SEL_LSB] = i[5:4];
			cyc(i[3:0] == 0 ? 9 : 1 + ($random(seed) & 7));
			periph_rd_on_system_clock = 1'($random(seed));
			periph_rd_req = 1'h1;
			cyc(1);
			periph_rd_req = 1'h0;
			for (n = 1; periph_rd_done_q !== 1'h1 && n < 20; n++) begin
				chk("stall", 1, cpu_stall_q);
				cyc(1);
			end
			chk("stall", 0, cpu_stall_q);
			chk("rdlat", 1, periph_rd_on_system_clock ? n == 1 : n <= (1 << i[5:4]));
			if (!periph_rd_on_system_clock) chk("rdedge", 1, periph_bus_clk_en_q);
			if (periph_bus_clk_en_q) chk("periph_bus_clock", 1, periph_bus_clock_q);
		end
		$display("read test done");
		print_verdict();
	end
endmodule : idle_wake_and_pb_clock_divider_tb
